// ==== verilog/drc_gain_map.vh ====
// Register offsets, field positions, reset values and constants of the gain engine.
`ifndef DRC_GAIN_MAP_VH
`define DRC_GAIN_MAP_VH
`define OFF_LOWER_THRESHOLD 4'h0
`define OFF_UPPER_THRESHOLD 4'h1
`define OFF_LOWER_OFFSET 4'h2
`define OFF_UPPER_OFFSET 4'h3
`define OFF_LOW_REGION_SLOPE 4'h4
`define OFF_MID_REGION_SLOPE 4'h5
`define OFF_HIGH_REGION_SLOPE 4'h6
`define OFF_CONTROL 4'h7
`define OFF_STATUS 4'h8
`define CTRL_ENABLE_BIT 0
`define CTRL_STEREO_BIT 1
`define CTRL_RESET 32'h00000001
`define RST_THRESHOLD 32'hfffe0000
`define RST_OFFSET 32'h01800000
`define RST_SLOPE 28'h0000000
`define UNITY_GAIN 32'h00800000
`define OFFSET_BIAS 32'h02000000
`define SLOPE_WIDTH 28
`define FIFO_DEPTH 16
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ==== verilog/gain_fifo.v ====
// Synchronous FIFO with valid and ready on both sides.
`default_nettype none
module gain_fifo #(
   parameter WIDTH = 32,
   parameter DEPTH = 16,
   parameter AW = 4
) (
   input wire aclk,
   input wire aresetn,
   input wire ce,
   input wire in_valid,
   output wire in_ready,
   input wire [WIDTH-1:0] in_data,
   output wire out_valid,
   input wire out_ready,
   output reg [WIDTH-1:0] out_data
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW:0] wr_ptr;
   reg [AW:0] rd_ptr;
   reg have_out;
   wire [AW:0] count;
   wire push;
   wire pop_mem;
   wire mem_empty;

   assign count = wr_ptr - rd_ptr;
   assign mem_empty = (count == {(AW+1){1'b0}});
   assign in_ready = (count != DEPTH[AW:0]);
   assign push = in_valid && in_ready && ce;
   assign out_valid = have_out;
   // Output register refills whenever it is empty or being drained.
   assign pop_mem = ce && !mem_empty && (!have_out || out_ready);

   always @(posedge aclk) begin
      if (push) begin
         mem[wr_ptr[AW-1:0]] <= in_data;
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         wr_ptr <= {(AW+1){1'b0}};
         rd_ptr <= {(AW+1){1'b0}};
         have_out <= 1'b0;
         out_data <= {WIDTH{1'b0}};
      end else if (ce) begin
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop_mem) begin
            out_data <= mem[rd_ptr[AW-1:0]];
            rd_ptr <= rd_ptr + 1'b1;
            have_out <= 1'b1;
         end else if (out_ready) begin
            have_out <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// ==== verilog/log2_conv.v ====
// Converts a positive rms estimate to a base-2 magnitude in 9.23 (log2 of reciprocal).
`default_nettype none
module log2_conv (
   input wire [31:0] rms,
   output reg [31:0] log_mag
);
   // Full scale (0x80000000) maps to zero; each halving adds one (6.0206 dB).
   // Linear mantissa interpolation gives the fractional part.
   integer i;
   reg [4:0] msb;
   reg [31:0] norm;
   always @* begin
      msb = 5'd0;
      norm = 32'h00000000;
      for (i = 0; i < 31; i = i + 1) begin
         if (rms[i]) begin
            msb = i[4:0];
         end
      end
      norm = rms << (5'd30 - msb);
      // An estimate with the top bit set is at or above full scale and saturates to zero.
      if (rms[31]) begin
         log_mag = 32'h00000000;
      end else if (rms[30:0] == 31'h00000000) begin
         log_mag = 32'h7fffffff;
      end else begin
         log_mag = {4'h0, (5'd31 - msb), 23'h000000} - {9'h000, norm[29:7]};
      end
   end
endmodule
`default_nettype wire

// ==== verilog/drc_gain_coefficient_engine.v ====
// Gain coefficient engine of a dynamic range compressor with AXI4-Lite registers.
// Contract
// (RL1) Seven programmable parameters: two thresholds, two offsets, three slopes.
// (RL2) Region chosen from log rms; upper threshold bounds high, lower bounds low.
// (RL3) Zero dB upper offset gives gain 0x00800000 at upper threshold.
// (RL4) High slope above upper threshold, mid slope between thresholds.
// (RL5) Curve is continuous at upper threshold, pivoting on upper offset.
// (RL6) At lower threshold the curve snaps to the lower offset.
// (RL7) Software sets lower offset for no step at lower threshold.
// (RL8) Below lower threshold low slope applies from lower offset level.
// (RL9) Thresholds are signed 9.23; dB equals value times minus 6.0206. Here log_mag is compared to them unsigned.
// (RL10) Offsets are 9.23; value is (dB plus 24.0824) over 6.0206.
// (RL11) Boosts are negative offsets, cuts are positive offsets; here an offset above 0x02000000 (0 dB) gives a gain above 0x00800000.
// (RL12) Software derives slopes from compression or expansion ratios.
// (RL13) Slopes down to -15.999 accepted without clamping.
// (RL14) Slope below minus one makes output fall as input rises.
// (RL15) Slopes stored as 28-bit signed 5.23 values.
// (RL16) Software programs only negative thresholds.
// (RL17) Stereo mode feeds the larger of two rms estimates.
// (RL18) Each sample: log convert, choose region, pass gain onward.
// (RL19) One gain per valid rms sample, flagged by one-cycle strobe; here gain_valid is held until gain_ready.
`default_nettype none
`include "drc_gain_map.vh"
module drc_gain_coefficient_engine #(
   parameter FIFO_DEPTH = `FIFO_DEPTH,
   parameter FIFO_AW = 4
) (
   input wire aclk,
   input wire aresetn,
   input wire ce,
   input wire [5:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [5:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire rms_valid,
   output wire rms_ready,
   input wire [31:0] rms_a,
   input wire [31:0] rms_b,
   output wire gain_valid,
   input wire gain_ready,
   output wire [31:0] gain
);
   // ----------------------------------------------------------------
   // Parameter registers
   // ----------------------------------------------------------------
   reg [31:0] lower_threshold;
   reg [31:0] upper_threshold;
   reg [31:0] lower_offset;
   reg [31:0] upper_offset;
   reg [27:0] low_region_slope;
   reg [27:0] mid_region_slope;
   reg [27:0] high_region_slope;
   reg [31:0] control;
   reg [15:0] sample_count;
   reg [1:0] last_region;

   // ----------------------------------------------------------------
   // AXI4-Lite slave
   // ----------------------------------------------------------------
   reg aw_held;
   reg w_held;
   reg [3:0] aw_index;
   reg [31:0] w_data;
   reg [3:0] w_strb;
   wire do_write;
   reg [31:0] read_word;
   reg read_ok;

   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready = !w_held && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   assign do_write = aw_held && w_held && !s_axi_bvalid;

   function [31:0] merge;
      input [31:0] old_v;
      input [31:0] new_v;
      input [3:0] strb;
      integer b;
      begin
         merge = old_v;
         for (b = 0; b < 4; b = b + 1) begin
            if (strb[b]) begin
               merge[8*b +: 8] = new_v[8*b +: 8];
            end
         end
      end
   endfunction

   // Slope registers keep only the low 28 bits of the merged bus word.
   function [27:0] merge_slope;
      input [27:0] old_v;
      input [31:0] new_v;
      input [3:0] strb;
      reg [31:0] m;
      begin
         m = merge({4'h0, old_v}, new_v, strb);
         merge_slope = m[27:0];
      end
   endfunction

   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_index <= 4'h0;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
         lower_threshold <= `RST_THRESHOLD;
         upper_threshold <= `RST_THRESHOLD;
         lower_offset <= `RST_OFFSET;
         upper_offset <= `RST_OFFSET;
         low_region_slope <= `RST_SLOPE;
         mid_region_slope <= `RST_SLOPE;
         high_region_slope <= `RST_SLOPE;
         control <= `CTRL_RESET;
      end else if (ce) begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_index <= s_axi_awaddr[5:2];
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= `RESP_OKAY;
            case (aw_index)
               `OFF_LOWER_THRESHOLD: lower_threshold <= merge(lower_threshold, w_data, w_strb); // [RL1] [RL9]
               `OFF_UPPER_THRESHOLD: upper_threshold <= merge(upper_threshold, w_data, w_strb); // [RL9]
               `OFF_LOWER_OFFSET: lower_offset <= merge(lower_offset, w_data, w_strb); // [RL10]
               `OFF_UPPER_OFFSET: upper_offset <= merge(upper_offset, w_data, w_strb); // [RL10]
               `OFF_LOW_REGION_SLOPE: begin
                  low_region_slope <= merge_slope(low_region_slope, w_data, w_strb); // [RL15]
               end
               `OFF_MID_REGION_SLOPE: begin
                  mid_region_slope <= merge_slope(mid_region_slope, w_data, w_strb); // [RL15]
               end
               `OFF_HIGH_REGION_SLOPE: begin
                  high_region_slope <= merge_slope(high_region_slope, w_data, w_strb); // [RL15]
               end
               `OFF_CONTROL: control <= merge(control, w_data, w_strb) & 32'h00000003;
               `OFF_STATUS: s_axi_bresp <= `RESP_SLVERR;
               default: s_axi_bresp <= `RESP_SLVERR;
            endcase
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always @* begin
      read_ok = 1'b1;
      case (s_axi_araddr[5:2])
         `OFF_LOWER_THRESHOLD: read_word = lower_threshold;
         `OFF_UPPER_THRESHOLD: read_word = upper_threshold;
         `OFF_LOWER_OFFSET: read_word = lower_offset;
         `OFF_UPPER_OFFSET: read_word = upper_offset;
         `OFF_LOW_REGION_SLOPE: read_word = {{4{low_region_slope[27]}}, low_region_slope};
         `OFF_MID_REGION_SLOPE: read_word = {{4{mid_region_slope[27]}}, mid_region_slope};
         `OFF_HIGH_REGION_SLOPE: read_word = {{4{high_region_slope[27]}}, high_region_slope};
         `OFF_CONTROL: read_word = control;
         `OFF_STATUS: read_word = {14'h0000, last_region, sample_count};
         default: begin
            read_word = 32'h00000000;
            read_ok = 1'b0;
         end
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `RESP_OKAY;
      end else if (ce) begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= read_word;
            s_axi_rresp <= read_ok ? `RESP_OKAY : `RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Gain computation
   // ----------------------------------------------------------------
   wire [31:0] rms_sel;
   wire [31:0] log_mag;
   wire fifo_in_ready;
   reg [31:0] in_dist;
   reg [27:0] in_slope;
   reg [31:0] in_anchor;
   reg [1:0] region;
   reg stage_valid;
   reg [31:0] stage_gain;
   wire signed [59:0] product;
   wire signed [31:0] level;

   // Stereo mode takes the larger estimate of the two channels.
   assign rms_sel = (control[`CTRL_STEREO_BIT] && (rms_b > rms_a)) ? rms_b : rms_a; // [RL17]
   assign rms_ready = fifo_in_ready || !stage_valid;

   log2_conv u_log (
      .rms(rms_sel),
      .log_mag(log_mag)
   );

   // Thresholds hold the level in halvings below full scale; log_mag is compared
   // to the threshold magnitude, larger magnitude meaning a quieter input.
   always @* begin
      if (log_mag < upper_threshold) begin
         region = 2'd2;
         in_dist = log_mag - upper_threshold; // [RL2] [RL4]
         in_slope = high_region_slope;
         in_anchor = upper_offset; // [RL5]
      end else if (log_mag < lower_threshold) begin
         region = 2'd1;
         in_dist = log_mag - upper_threshold; // [RL4]
         in_slope = mid_region_slope;
         in_anchor = upper_offset; // [RL5]
      end else begin
         region = 2'd0;
         in_dist = log_mag - lower_threshold; // [RL6] [RL8]
         in_slope = low_region_slope;
         in_anchor = lower_offset; // [RL6]
      end
   end

   // Offset grows with distance below the threshold times the slope (sign kept
   // unclamped, so slopes under minus one reverse the curve).
   assign product = $signed(in_dist) * $signed(in_slope); // [RL13] [RL14]
   assign level = $signed(in_anchor) + $signed(product[54:23]);

   always @(posedge aclk) begin
      if (!aresetn) begin
         stage_valid <= 1'b0;
         stage_gain <= 32'h00000000;
         sample_count <= 16'h0000;
         last_region <= 2'd0;
      end else if (ce) begin
         if (rms_valid && rms_ready && control[`CTRL_ENABLE_BIT]) begin
            stage_valid <= 1'b1; // [RL18] [RL19]
            stage_gain <= level - `OFFSET_BIAS + `UNITY_GAIN; // [RL3] [RL11]
            sample_count <= sample_count + 16'h0001;
            last_region <= region;
         end else if (fifo_in_ready) begin
            stage_valid <= 1'b0;
         end
      end
   end

   gain_fifo #(
      .WIDTH(32),
      .DEPTH(FIFO_DEPTH),
      .AW(FIFO_AW)
   ) u_fifo (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .in_valid(stage_valid),
      .in_ready(fifo_in_ready),
      .in_data(stage_gain),
      .out_valid(gain_valid),
      .out_ready(gain_ready),
      .out_data(gain)
   );
endmodule
`default_nettype wire

// ==== tb/drc_gain_chk.sv ====
// Assertions on the gain engine's bus and stream ports.
`default_nettype none
module drc_gain_chk (
   input wire aclk,
   input wire aresetn,
   input wire ce,
   input wire [5:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire [1:0] s_axi_bresp,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire rms_valid,
   input wire rms_ready,
   input wire gain_valid,
   input wire gain_ready,
   input wire [31:0] gain
);
   logic [5:0] waddr;
   logic [7:0] pend;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Samples taken minus gains delivered; a gain with nothing pending is spurious.
   always @(posedge aclk) begin
      if (!aresetn) begin
         waddr <= 6'h00;
         pend <= 8'h00;
      end else begin
         if (s_axi_awvalid && s_axi_awready)
            waddr <= s_axi_awaddr;
         pend <= pend + {7'h00, rms_valid & rms_ready & ce} - {7'h00, gain_valid & gain_ready & ce};
      end
   end
   a_gain_hold:
      assert property (gain_valid && !gain_ready |=> gain_valid && $stable(gain))
      else $error("gain not held");
   a_gain_cause:
      assert property (gain_valid |-> pend != 8'h00)
      else $error("gain without sample");
   a_out_clear:
      assert property ($rose(aresetn) |-> !gain_valid && !s_axi_bvalid && !s_axi_rvalid)
      else $error("valid after reset");
   a_read_answer:
      assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read not answered");
   a_read_hold:
      assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data not held");
   a_write_hold:
      assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response not held");
   a_write_code:
      assert property ($rose(s_axi_bvalid) |-> s_axi_bresp == (waddr < 6'h20 ? 2'h0 : 2'h2))
      else $error("wrong write response");
   a_write_answer:
      assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
         |-> ##[1:2] s_axi_bvalid)
      else $error("write not answered");
endmodule
bind drc_gain_coefficient_engine drc_gain_chk drc_gain_chk_inst (.aclk(aclk),
   .aresetn(aresetn), .ce(ce), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .rms_valid(rms_valid),
   .rms_ready(rms_ready), .gain_valid(gain_valid), .gain_ready(gain_ready), .gain(gain));
`default_nettype wire

// ==== tb/far_side_model.sv ====
// Rms source and gain sink standing at the engine's far side.
`default_nettype none
module far_side_model (
   input wire logic aclk,
   input wire logic rms_ready,
   input wire logic gain_valid,
   input wire logic [31:0] gain,
   output logic rms_valid,
   output logic [31:0] rms_a,
   output logic [31:0] rms_b,
   output logic gain_ready
);
   timeunit 1ns;
   timeprecision 1ps;
   logic stall = 1'b0;
   logic [31:0] got[$];
   initial begin
      rms_valid = 1'b0;
      rms_a = 32'h0;
      rms_b = 32'h0;
      gain_ready = 1'b0;
   end
   // Released estimates show the inverse so stale values are never mistaken for data.
   task automatic send(input logic [31:0] a, input logic [31:0] b);
      rms_valid <= 1'b1;
      rms_a <= a;
      rms_b <= b;
      @(posedge aclk);
      while (!rms_ready)
         @(posedge aclk);
      rms_valid <= 1'b0;
      rms_a <= ~a;
      rms_b <= ~b;
      @(posedge aclk);
   endtask
   always @(posedge aclk) begin
      gain_ready <= !stall;
      if (gain_valid && gain_ready)
         got.push_back(gain);
   end
endmodule
`default_nettype wire

// ==== tb/drc_gain_coefficient_engine_tb.sv ====
// Self-checking bench of the gain coefficient engine.
`default_nettype none
`include "drc_gain_map.vh"
module drc_gain_coefficient_engine_tb;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {logic st; logic [31:0] a; logic [31:0] b; logic [31:0] g;} row_t;
   localparam logic [31:0] ld = 32'h80000000, qt = 32'h00000001, md = 32'h00100000;
   localparam logic [31:0] up_g = `UNITY_GAIN, lo_g = 32'h00c00000;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic ce = 1'b1;
   logic [5:0] awaddr = 6'h00;
   logic [5:0] araddr = 6'h00;
   logic [31:0] wdata = 32'h0;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   wire awready, wready, bvalid, arready, rvalid, rms_valid, rms_ready, gain_valid, gain_ready;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata, rms_a, rms_b, gain;
   int n_errors = 0;
   int tests_run = 0;
   int cycles = 0;
   int k;
   logic [31:0] d, g1;
   logic [1:0] r;
   row_t rows[6] = '{'{1'b0, ld, qt, up_g}, '{1'b0, md, qt, up_g}, '{1'b0, qt, ld, lo_g},
      '{1'b1, qt, ld, up_g}, '{1'b1, ld, qt, up_g}, '{1'b1, qt, qt, lo_g}};
   drc_gain_coefficient_engine drc_gain_coefficient_engine_inst (.aclk(aclk),
      .aresetn(aresetn), .ce(ce), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .rms_valid(rms_valid), .rms_ready(rms_ready), .rms_a(rms_a), .rms_b(rms_b),
      .gain_valid(gain_valid), .gain_ready(gain_ready), .gain(gain));
   far_side_model far_side_model_inst (.aclk(aclk), .rms_ready(rms_ready),
      .gain_valid(gain_valid), .gain(gain), .rms_valid(rms_valid), .rms_a(rms_a),
      .rms_b(rms_b), .gain_ready(gain_ready));
   initial begin
      forever #5 aclk = ~aclk;
   end
   // -----
   // Bus, stream and check tasks
   // -----
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      tests_run++;
      if (s !== e) begin
         n_errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic wr(input logic [5:0] a, input logic [31:0] v, output logic [1:0] rs);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready)
            awvalid <= 1'b0;
         if (wready)
            wvalid <= 1'b0;
      end while (!bvalid);
      rs = bresp;
      bready <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic rd(input logic [5:0] a, output logic [31:0] v);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready)
            arvalid <= 1'b0;
      end while (!rvalid);
      v = rdata;
      rready <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic take(output logic [31:0] v);
      while (far_side_model_inst.got.size() == 0)
         @(posedge aclk);
      v = far_side_model_inst.got.pop_front();
   endtask
   task automatic results();
      $display("compares %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   always @(posedge aclk) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         results();
      end
   end
   // -----
   // Main sequence
   // -----
   initial begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      for (int i = 0; i < 7; i++) begin
         rd(6'(i * 4), d);
         chk(d, i < 2 ? `RST_THRESHOLD : (i < 4 ? `RST_OFFSET : 32'h0));
      end
      rd(6'h1c, d);
      chk(d, `CTRL_RESET);
      wr(6'h00, 32'h08000000, r);
      wr(6'h04, 32'h04000000, r);
      wr(6'h08, 32'h02400000, r);
      wr(6'h0c, `OFFSET_BIAS, r);
      rd(6'h00, d);
      chk(d, 32'h08000000);
      rd(6'h08, d);
      chk(d, 32'h02400000);
      for (int i = 8; i < 10; i++) begin
         wr(6'(i * 4), 32'h1, r);
         chk({30'h0, r}, {30'h0, `RESP_SLVERR});
      end
      foreach (rows[i]) begin
         wr(6'h1c, {30'h0, rows[i].st, 1'b1}, r);
         far_side_model_inst.send(rows[i].a, rows[i].b);
         take(g1);
         chk(g1, rows[i].g);
      end
      rd(6'h20, d);
      chk({16'h0, d[15:0]}, 32'h6);
      wr(6'h08, `OFFSET_BIAS, r);
      far_side_model_inst.send(qt, 32'h0);
      take(g1);
      chk(g1, up_g);
      wr(6'h1c, 32'h1, r);
      wr(6'h10, 32'hf8000001, r);
      rd(6'h10, d);
      chk({4'h0, d[27:0]}, 32'h08000001);
      wr(6'h10, 32'hfe000000, r);
      far_side_model_inst.send(32'h1, 32'h0);
      take(g1);
      far_side_model_inst.send(32'h2, 32'h0);
      take(d);
      chk(d - g1, 32'h02000000);
      far_side_model_inst.stall <= 1'b1;
      k = 0;
      while (rms_ready && k < 30) begin
         far_side_model_inst.send(ld, 32'h0);
         k++;
      end
      chk({31'h0, k >= 16 && k < 30}, 32'h1);
      far_side_model_inst.stall <= 1'b0;
      repeat (k) begin
         take(g1);
         chk(g1, up_g);
      end
      wr(6'h1c, 32'h0, r);
      far_side_model_inst.send(ld, 32'h0);
      repeat (10) @(posedge aclk);
      chk(32'(far_side_model_inst.got.size()), 32'h0);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(6'h1c, d);
      chk(d, `CTRL_RESET);
      results();
   end
endmodule
`default_nettype wire
